//--- hdl/numeric_ctl_pkg.sv
package numeric_ctl_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IADDR_W = 20;
	localparam int OPC_W = 11;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_COND = 8'h08;
	localparam logic [7:0] OFS_TAG = 8'h0C;
	localparam logic [7:0] OFS_IPTR = 8'h10;
	localparam logic [7:0] OFS_OPTR = 8'h14;
	localparam logic [7:0] OFS_OPCODE = 8'h18;
	// reset values
	localparam logic [15:0] CTRL_RESET = 16'h03BF;
	localparam logic [15:0] TAG_RESET = 16'hFFFF;
	// control and status word fields
	localparam int CTL_GMASK_BIT = 7;
	localparam int CTL_PREC_LSB = 8;
	localparam int CTL_RND_LSB = 10;
	localparam int CTL_INF_BIT = 12;
	localparam int STS_IRQ_BIT = 7;
	// exception bit positions
	localparam int EXC_INVALID = 0;
	localparam int EXC_DENORM = 1;
	localparam int EXC_ZDIV = 2;
	localparam int EXC_OVFL = 3;
	localparam int EXC_UNFL = 4;
	localparam int EXC_INEXACT = 5;
	// precision and rounding codes
	localparam logic [1:0] PREC_SINGLE = 2'h0;
	localparam logic [1:0] PREC_DOUBLE = 2'h2;
	localparam logic [1:0] PREC_EXTENDED = 2'h3;
	localparam logic [1:0] RND_NEAREST = 2'h0;
	localparam logic [1:0] RND_DOWN = 2'h1;
	localparam logic [1:0] RND_UP = 2'h2;
	localparam logic [1:0] RND_TRUNC = 2'h3;
	// operation kinds and outcome codes
	localparam logic [1:0] OPK_OTHER = 2'h0;
	localparam logic [1:0] OPK_COMPARE = 2'h1;
	localparam logic [1:0] OPK_REMAINDER = 2'h2;
	localparam logic [1:0] OPK_EXAMINE = 2'h3;
	localparam logic [1:0] CMP_GT = 2'h0;
	localparam logic [1:0] CMP_LT = 2'h1;
	localparam logic [1:0] CMP_EQ = 2'h2;
	localparam logic [1:0] CMP_UNORD = 2'h3;
	localparam logic [1:0] REM_BELOW2 = 2'h0;
	localparam logic [1:0] REM_BELOW4 = 2'h1;
	localparam logic [1:0] REM_ABOVE4 = 2'h2;
	// default responses handed to the datapath
	typedef enum logic [2:0] {
		RESP_NONE, RESP_DEFAULT_VALUE, RESP_PROPAGATE, RESP_INFINITY,
		RESP_DENORMALIZE, RESP_ROUND, RESP_CONTINUE
	} resp_e;
endpackage : numeric_ctl_pkg

//--- hdl/numeric_control_exception_logic.sv
`timescale 1ns/100ps
module numeric_control_exception_logic (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// register port
	input wire logic [numeric_ctl_pkg::ADDR_W-1:0] i_reg_addr,
	input wire logic [numeric_ctl_pkg::DATA_W-1:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [numeric_ctl_pkg::DATA_W-1:0] o_reg_rdata,
	// instruction issue
	input wire logic i_issue,
	input wire logic [numeric_ctl_pkg::IADDR_W-1:0] i_instr_addr,
	input wire logic i_opnd_present,
	input wire logic [numeric_ctl_pkg::IADDR_W-1:0] i_opnd_addr,
	input wire logic [numeric_ctl_pkg::OPC_W-1:0] i_opcode,
	// tag update from the stack
	input wire logic i_tag_we,
	input wire logic [2:0] i_tag_idx,
	input wire logic [1:0] i_tag_val,
	// execution outcome
	input wire logic i_done,
	input wire logic [1:0] i_op_kind,
	input wire logic [1:0] i_cmp_res,
	input wire logic i_rem_complete,
	input wire logic [1:0] i_rem_range,
	input wire logic [2:0] i_quot,
	input wire logic i_exam_sign,
	input wire logic [2:0] i_exam_class,
	// exception causes
	input wire logic i_stack_ovf,
	input wire logic i_stack_unf,
	input wire logic i_indeterminate,
	input wire logic i_bad_operand,
	input wire logic i_res_too_big,
	input wire logic i_divisor_zero,
	input wire logic i_dividend_finite_nz,
	input wire logic i_res_too_small,
	input wire logic i_denorm_seen,
	input wire logic i_not_exact,
	// mode outputs
	output logic [1:0] o_prec,
	output logic [1:0] o_round,
	output logic o_affine,
	// status outputs
	output logic [3:0] o_cond,
	output logic [5:0] o_exc_flags,
	output logic o_irq_bit,
	output logic o_int,
	output logic o_hold,
	output numeric_ctl_pkg::resp_e o_resp,
	output logic o_resp_valid
);
	// registers
	logic [15:0] ctrl_q, ctrl_d;
	logic [5:0] flags_q, flags_d;
	logic [3:0] cond_q, cond_d;
	logic [15:0] tag_q, tag_d;
	logic [numeric_ctl_pkg::IADDR_W-1:0] iptr_q, optr_q;
	logic [numeric_ctl_pkg::OPC_W-1:0] opc_q;
	logic [numeric_ctl_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic irq_q, int_q, hold_q, resp_valid_q;
	numeric_ctl_pkg::resp_e resp_q, resp_d;

	// address decode
	wire sel_ctrl = (i_reg_addr == numeric_ctl_pkg::OFS_CTRL);
	wire sel_status = (i_reg_addr == numeric_ctl_pkg::OFS_STATUS);
	wire sel_cond = (i_reg_addr == numeric_ctl_pkg::OFS_COND);
	wire sel_tag = (i_reg_addr == numeric_ctl_pkg::OFS_TAG);
	wire sel_iptr = (i_reg_addr == numeric_ctl_pkg::OFS_IPTR);
	wire sel_optr = (i_reg_addr == numeric_ctl_pkg::OFS_OPTR);
	wire sel_opc = (i_reg_addr == numeric_ctl_pkg::OFS_OPCODE);

	// control word fields
	wire [5:0] exc_mask = ctrl_q[5:0];
	wire gmask = ctrl_q[numeric_ctl_pkg::CTL_GMASK_BIT];
	wire [1:0] prec_field = ctrl_q[numeric_ctl_pkg::CTL_PREC_LSB +: 2];
	wire [1:0] rnd_field = ctrl_q[numeric_ctl_pkg::CTL_RND_LSB +: 2];

	// reserved precision code falls back to extended
	wire [1:0] prec_sel = (prec_field == numeric_ctl_pkg::PREC_SINGLE ||
		prec_field == numeric_ctl_pkg::PREC_DOUBLE) ? prec_field :
		numeric_ctl_pkg::PREC_EXTENDED;
	wire [1:0] rnd_sel = rnd_field; // all four codes used

	// exception detection for this completion
	wire det_invalid = i_stack_ovf | i_stack_unf | i_indeterminate | i_bad_operand;
	wire det_zdiv = i_divisor_zero & i_dividend_finite_nz;
	wire [5:0] det = {i_not_exact, i_res_too_small, i_res_too_big, det_zdiv,
		i_denorm_seen, det_invalid};
	wire [5:0] det_now = i_done ? det : 6'h00;

	// software clear: write ones to the status word
	wire [5:0] sw_clr = (i_reg_wr && sel_status) ? i_reg_wdata[5:0] : 6'h00;

	// sticky flags, a new event beats a same-cycle clear
	assign flags_d = (flags_q & ~sw_clr) | det_now;

	// request bit and interrupt from next flag state
	wire irq_d = |(flags_d & ~exc_mask);
	wire int_d = irq_d & ~gmask;
	// only an enabled interrupt holds execution
	wire hold_d = int_d;

	// masked default response, highest priority first
	wire [5:0] masked_det = det & exc_mask;
	always_comb begin
		resp_d = numeric_ctl_pkg::RESP_NONE;
		if (masked_det[numeric_ctl_pkg::EXC_INVALID]) begin
			resp_d = i_bad_operand ? numeric_ctl_pkg::RESP_PROPAGATE :
				numeric_ctl_pkg::RESP_DEFAULT_VALUE;
		end else if (masked_det[numeric_ctl_pkg::EXC_ZDIV]) begin
			resp_d = numeric_ctl_pkg::RESP_INFINITY;
		end else if (masked_det[numeric_ctl_pkg::EXC_OVFL]) begin
			resp_d = numeric_ctl_pkg::RESP_INFINITY;
		end else if (masked_det[numeric_ctl_pkg::EXC_UNFL]) begin
			resp_d = numeric_ctl_pkg::RESP_DENORMALIZE;
		end else if (masked_det[numeric_ctl_pkg::EXC_INEXACT]) begin
			resp_d = numeric_ctl_pkg::RESP_ROUND;
		end else if (masked_det[numeric_ctl_pkg::EXC_DENORM]) begin
			resp_d = numeric_ctl_pkg::RESP_CONTINUE;
		end
	end

	// condition code update, bits {three, two, one, zero}
	always_comb begin
		cond_d = cond_q;
		if (i_done) begin
			unique case (i_op_kind)
				numeric_ctl_pkg::OPK_COMPARE: begin
					unique case (i_cmp_res)
						numeric_ctl_pkg::CMP_GT: cond_d = {2'h0, cond_q[1], 1'h0};
						numeric_ctl_pkg::CMP_LT: cond_d = {2'h0, cond_q[1], 1'h1};
						numeric_ctl_pkg::CMP_EQ: cond_d = {2'h2, cond_q[1], 1'h0};
						numeric_ctl_pkg::CMP_UNORD: cond_d = {2'h3, cond_q[1], 1'h1};
					endcase
				end
				numeric_ctl_pkg::OPK_REMAINDER: begin
					if (i_rem_complete) begin
						cond_d[2] = 1'h0;
						cond_d[0] = i_quot[2];
						if (i_rem_range != numeric_ctl_pkg::REM_BELOW2) begin
							cond_d[1] = i_quot[0];
						end
						if (i_rem_range == numeric_ctl_pkg::REM_ABOVE4) begin
							cond_d[3] = i_quot[1];
						end
					end else begin
						cond_d[2] = 1'h1; // others left as they were
					end
				end
				numeric_ctl_pkg::OPK_EXAMINE: begin
					cond_d = {i_exam_class[2:1], i_exam_sign, i_exam_class[0]};
				end
				numeric_ctl_pkg::OPK_OTHER: cond_d = cond_q;
			endcase
		end
	end

	// tag word: stack updates win over software writes
	always_comb begin
		tag_d = tag_q;
		if (i_reg_wr && sel_tag) begin
			tag_d = i_reg_wdata[15:0];
		end
		if (i_tag_we) begin
			tag_d[{i_tag_idx, 1'h0} +: 2] = i_tag_val;
		end
	end

	// control word write
	assign ctrl_d = (i_reg_wr && sel_ctrl) ? i_reg_wdata[15:0] : ctrl_q;

	// read data mux, unmapped reads return zero
	always_comb begin
		rdata_d = '0;
		if (i_reg_rd) begin
			if (sel_ctrl) rdata_d[15:0] = ctrl_q;
			if (sel_status) rdata_d[7:0] = {irq_q, 1'h0, flags_q};
			if (sel_cond) rdata_d[3:0] = cond_q;
			if (sel_tag) rdata_d[15:0] = tag_q;
			if (sel_iptr) rdata_d[numeric_ctl_pkg::IADDR_W-1:0] = iptr_q;
			if (sel_optr) rdata_d[numeric_ctl_pkg::IADDR_W-1:0] = optr_q;
			if (sel_opc) rdata_d[numeric_ctl_pkg::OPC_W-1:0] = opc_q;
		end
	end

	// software-visible state
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			ctrl_q <= numeric_ctl_pkg::CTRL_RESET;
			flags_q <= 6'h00;
			cond_q <= 4'h0;
			tag_q <= numeric_ctl_pkg::TAG_RESET;
			rdata_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			flags_q <= flags_d;
			cond_q <= cond_d;
			tag_q <= tag_d;
			rdata_q <= rdata_d;
		end
	end

	// pointer capture on each issued instruction, operand pointer only when an operand is present
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			iptr_q <= '0;
			optr_q <= '0;
			opc_q <= '0;
		end else if (i_issue) begin
			iptr_q <= i_instr_addr;
			opc_q <= i_opcode;
			if (i_opnd_present) optr_q <= i_opnd_addr;
		end
	end

	// interrupt and response outputs
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			irq_q <= 1'h0;
			int_q <= 1'h0;
			hold_q <= 1'h0;
			resp_q <= numeric_ctl_pkg::RESP_NONE;
			resp_valid_q <= 1'h0;
		end else begin
			irq_q <= irq_d;
			int_q <= int_d;
			hold_q <= hold_d;
			resp_q <= i_done ? resp_d : numeric_ctl_pkg::RESP_NONE;
			resp_valid_q <= i_done;
		end
	end

	// outputs straight from flops
	assign o_reg_rdata = rdata_q;
	assign o_prec = prec_sel_q;
	assign o_round = ctrl_q[numeric_ctl_pkg::CTL_RND_LSB +: 2];
	assign o_affine = ctrl_q[numeric_ctl_pkg::CTL_INF_BIT];
	assign o_cond = cond_q;
	assign o_exc_flags = flags_q;
	assign o_irq_bit = irq_q;
	assign o_int = int_q;
	assign o_hold = hold_q;
	assign o_resp = resp_q;
	assign o_resp_valid = resp_valid_q;

	// registered precision select
	logic [1:0] prec_sel_q;
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) prec_sel_q <= numeric_ctl_pkg::PREC_EXTENDED;
		else prec_sel_q <= (i_reg_wr && sel_ctrl) ? prec_of(i_reg_wdata[9:8]) : prec_sel;
	end

	// precision decode for the write path; steady state uses the separate prec_sel logic
	function automatic logic [1:0] prec_of(input logic [1:0] f);
		prec_of = (f == numeric_ctl_pkg::PREC_SINGLE || f == numeric_ctl_pkg::PREC_DOUBLE) ?
			f : numeric_ctl_pkg::PREC_EXTENDED;
	endfunction : prec_of

	// checks
	AST_FLAG_SET: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_done |=> (flags_q & $past(det)) == $past(det))
		else $error("detected exception not recorded");
	AST_STICKY: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		!(i_reg_wr && sel_status) |=> (flags_q & $past(flags_q)) == $past(flags_q))
		else $error("flag dropped without software clear");
	AST_IRQ_BIT: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		irq_q == |(flags_q & ~exc_mask) || $past(i_reg_wr && sel_ctrl))
		else $error("request bit does not track unmasked flags");
	AST_INT_GMASK: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		o_int |-> irq_q && !$past(gmask))
		else $error("interrupt while globally masked");
	AST_NO_HOLD_DISABLED: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		gmask && $stable(ctrl_q) |=> !o_hold)
		else $error("execution held with interrupts disabled");
	AST_CMP_EQ: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_done && i_op_kind == numeric_ctl_pkg::OPK_COMPARE && i_cmp_res == numeric_ctl_pkg::CMP_EQ
		|=> cond_q == {2'h2, $past(cond_q[1]), 1'h0})
		else $error("equal compare code wrong");
	AST_REM_KEEP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_done && i_op_kind == numeric_ctl_pkg::OPK_REMAINDER && i_rem_complete &&
		i_rem_range == numeric_ctl_pkg::REM_BELOW2
		|=> cond_q == {$past(cond_q[3]), 1'h0, $past(cond_q[1]), $past(i_quot[2])})
		else $error("remainder altered kept bits");
	AST_EXAMINE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_done && i_op_kind == numeric_ctl_pkg::OPK_EXAMINE
		|=> o_cond[1] == $past(i_exam_sign) && o_cond[3] == $past(i_exam_class[2]))
		else $error("examine code wrong");
	AST_INF_RESP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_done && exc_mask[numeric_ctl_pkg::EXC_ZDIV] && det_zdiv && !det_invalid
		|=> o_resp == numeric_ctl_pkg::RESP_INFINITY && o_resp_valid)
		else $error("masked zero divide without infinity");
	AST_INVALID_RESP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_done && exc_mask[numeric_ctl_pkg::EXC_INVALID] && i_stack_unf && !i_bad_operand
		|=> o_resp == numeric_ctl_pkg::RESP_DEFAULT_VALUE)
		else $error("masked invalid without default value");
	AST_ISSUE_CAPTURE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_issue |=> iptr_q == $past(i_instr_addr) && opc_q == $past(i_opcode))
		else $error("pointer capture missed");
	COV_INT: cover property (@(posedge i_mclk) disable iff (!i_reset_n) $rose(o_int));
	COV_MASKED: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		o_resp_valid && o_resp != numeric_ctl_pkg::RESP_NONE);
	COV_SET_CLR: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_done && |det && i_reg_wr && sel_status);
	COV_REM: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_done && i_op_kind == numeric_ctl_pkg::OPK_REMAINDER && !i_rem_complete);
endmodule : numeric_control_exception_logic

//--- tb/host_escape_model.sv
`timescale 1ns/100ps
// host side: issues escape instructions and reports how each one ended
module host_escape_model (
	// clock
	input wire logic i_mclk,
	// instruction issue
	output logic o_issue,
	output logic o_present,
	output logic [19:0] o_iaddr,
	output logic [19:0] o_oaddr,
	output logic [10:0] o_opcode,
	// instruction outcome
	output logic o_done,
	output logic [1:0] o_kind,
	output logic [6:0] o_res,
	output logic [9:0] o_cause
);
	// idle levels at time zero
	initial begin
		{o_issue, o_present, o_iaddr, o_oaddr, o_opcode} = 53'h0;
		{o_done, o_kind, o_res, o_cause} = 20'h0;
	end

	// issue pulse, slow cycles of work, completion pulse; released fields are scrambled
	task automatic run(input logic [51:0] ins, input logic [1:0] kind, input logic [6:0] res,
		input logic [9:0] cause, input int slow);
		@(posedge i_mclk);
		{o_iaddr, o_present, o_oaddr, o_opcode} <= ins;
		o_issue <= 1'h1;
		@(posedge i_mclk);
		o_issue <= 1'h0;
		{o_iaddr, o_present, o_oaddr, o_opcode} <= ~ins;
		repeat (slow) @(posedge i_mclk);
		{o_done, o_kind, o_res, o_cause} <= {1'h1, kind, res, cause};
		@(posedge i_mclk);
		{o_done, o_kind, o_res, o_cause} <= {1'h0, ~kind, ~res, ~cause};
	endtask : run
endmodule : host_escape_model

//--- tb/numeric_control_exception_logic_tb_top.sv
`timescale 1ns/100ps
module numeric_control_exception_logic_tb_top;
	// bench state and design connections
	logic i_mclk = 1'h0;
	logic i_reset_n = 1'h0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [31:0] i_reg_wdata = 32'h0;
	logic i_reg_wr = 1'h0;
	logic i_reg_rd = 1'h0;
	logic i_tag_we = 1'h0;
	logic [2:0] i_tag_idx = 3'h0;
	logic [1:0] i_tag_val = 2'h0;
	logic h_issue, h_present, h_done;
	logic [19:0] h_iaddr, h_oaddr;
	logic [10:0] h_opcode;
	logic [1:0] h_kind;
	logic [6:0] h_res;
	logic [9:0] h_cause;
	logic [31:0] o_reg_rdata;
	logic [1:0] o_prec, o_round;
	logic [3:0] o_cond;
	logic [5:0] o_exc_flags, flag_exp;
	logic o_affine, o_irq_bit, o_int, o_hold, o_resp_valid;
	numeric_ctl_pkg::resp_e o_resp;
	logic [15:0] lfsr_state = 16'h45A2;
	logic [63:0] r64;
	logic [19:0] optr_exp = 20'h0;
	logic [15:0] tag_exp;
	logic [3:0] cond_exp = 4'h0;
	logic [31:0] v;
	int err_count = 0;
	int checks_done = 0;

	// free-running clock
	always #5 i_mclk = ~i_mclk;

	host_escape_model u_host (.i_mclk(i_mclk), .o_issue(h_issue), .o_present(h_present),
		.o_iaddr(h_iaddr), .o_oaddr(h_oaddr), .o_opcode(h_opcode), .o_done(h_done),
		.o_kind(h_kind), .o_res(h_res), .o_cause(h_cause));

	numeric_control_exception_logic DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_issue(h_issue),
		.i_instr_addr(h_iaddr), .i_opnd_present(h_present), .i_opnd_addr(h_oaddr),
		.i_opcode(h_opcode), .i_tag_we(i_tag_we), .i_tag_idx(i_tag_idx), .i_tag_val(i_tag_val),
		.i_done(h_done), .i_op_kind(h_kind), .i_cmp_res(h_res[1:0]), .i_rem_complete(h_res[2]),
		.i_rem_range(h_res[1:0]), .i_quot(h_res[5:3]), .i_exam_sign(h_res[6]),
		.i_exam_class(h_res[5:3]), .i_stack_ovf(h_cause[0]), .i_stack_unf(h_cause[1]),
		.i_indeterminate(h_cause[2]), .i_bad_operand(h_cause[3]), .i_res_too_big(h_cause[4]),
		.i_divisor_zero(h_cause[5]), .i_dividend_finite_nz(h_cause[6]),
		.i_res_too_small(h_cause[7]), .i_denorm_seen(h_cause[8]), .i_not_exact(h_cause[9]),
		.o_prec(o_prec), .o_round(o_round), .o_affine(o_affine), .o_cond(o_cond),
		.o_exc_flags(o_exc_flags), .o_irq_bit(o_irq_bit), .o_int(o_int), .o_hold(o_hold),
		.o_resp(o_resp), .o_resp_valid(o_resp_valid));

	// shift register random source
	function logic [15:0] next_rand();
		lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
		return lfsr_state;
	endfunction : next_rand

	// expected condition bits {c3,c2,c1,c0} after an operation
	function automatic logic [3:0] exp_cond(input logic [1:0] kind, input logic [6:0] res,
		input logic [3:0] old);
		logic [1:0] c;
		logic [2:0] q;
		c = res[1:0];
		q = res[5:3];
		case (kind)
			numeric_ctl_pkg::OPK_COMPARE: return {c == numeric_ctl_pkg::CMP_EQ || c == 2'h3,
				c == numeric_ctl_pkg::CMP_UNORD, old[1], c == numeric_ctl_pkg::CMP_LT || c == 2'h3};
			numeric_ctl_pkg::OPK_REMAINDER: begin
				if (!res[2]) return {old[3], 1'h1, old[1:0]};
				return {c == numeric_ctl_pkg::REM_ABOVE4 ? q[1] : old[3], 1'h0,
					c == numeric_ctl_pkg::REM_BELOW2 ? old[1] : q[0], q[2]};
			end
			numeric_ctl_pkg::OPK_EXAMINE: return {q[2], q[1], res[6], q[0]};
			default: return old;
		endcase
	endfunction : exp_cond

	// cause pattern, flag and masked response of exception case k
	function automatic logic [9:0] cause_of(input int k);
		if (k < 5) return 10'h1 << k;
		if (k == 5) return 10'h060;
		return 10'h1 << (k + 1);
	endfunction : cause_of

	function automatic logic [5:0] flag_of(input int k);
		case (k)
			4: return 6'h08;
			5: return 6'h04;
			6: return 6'h10;
			7: return 6'h02;
			8: return 6'h20;
			default: return 6'h01;
		endcase
	endfunction : flag_of

	function automatic numeric_ctl_pkg::resp_e resp_of(input int k);
		case (k)
			3: return numeric_ctl_pkg::RESP_PROPAGATE;
			4, 5: return numeric_ctl_pkg::RESP_INFINITY;
			6: return numeric_ctl_pkg::RESP_DENORMALIZE;
			7: return numeric_ctl_pkg::RESP_CONTINUE;
			8: return numeric_ctl_pkg::RESP_ROUND;
			default: return numeric_ctl_pkg::RESP_DEFAULT_VALUE;
		endcase
	endfunction : resp_of

	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// register bus write and read
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		{i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'h1, a, d};
		@(posedge i_mclk);
		i_reg_wr <= 1'h0;
	endtask : wr

	task rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_mclk);
		{i_reg_rd, i_reg_addr} <= {1'h1, a};
		@(posedge i_mclk);
		i_reg_rd <= 1'h0;
		#1;
		chk(o_reg_rdata, e, "read");
	endtask : rchk

	// one instruction through the host, then its outcome
	task automatic do_op(input logic [1:0] kind, input logic [6:0] res, input logic [9:0] cause);
		r64 = {next_rand(), next_rand(), next_rand(), next_rand()};
		u_host.run(r64[51:0], kind, res, cause, int'(r64[63:62]));
		if (r64[31]) optr_exp = r64[30:11];
		cond_exp = exp_cond(kind, res, cond_exp);
		#1;
		chk(o_cond, cond_exp, "cond");
		chk(o_resp_valid, 1'h1, "resp valid");
	endtask : do_op

	// verdict
	task stop_test();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	// hang guard
	initial begin
		repeat (100000) @(posedge i_mclk);
		err_count++;
		$display("[FAIL] %0t timeout", $time);
		stop_test();
	end

	// main sequence
	initial begin
		repeat (4) @(posedge i_mclk);
		i_reset_n <= 1'h1;
		rchk(numeric_ctl_pkg::OFS_CTRL, 32'h03BF);
		rchk(numeric_ctl_pkg::OFS_TAG, 32'hFFFF);
		rchk(numeric_ctl_pkg::OFS_STATUS, 32'h0);
		wr(numeric_ctl_pkg::OFS_IPTR, 32'hFFFFF);
		rchk(numeric_ctl_pkg::OFS_IPTR, 32'h0);
		rchk(8'h1C, 32'h0);
		for (int r = 0; r < 4; r++) begin
			for (int p = 0; p < 4; p++) begin
				if (p != 1) begin
					v = {19'h0, r[0], r[1:0], p[1:0], 8'hBF};
					wr(numeric_ctl_pkg::OFS_CTRL, v);
					rchk(numeric_ctl_pkg::OFS_CTRL, v);
					chk(o_round, r[1:0], "round");
					chk(o_prec, p[1:0], "prec");
					chk(o_affine, r[0], "affine");
				end
			end
		end
		wr(numeric_ctl_pkg::OFS_CTRL, 32'h03BF);
		repeat (6) begin
			do_op(numeric_ctl_pkg::OPK_OTHER, 7'h0, 10'h0);
			rchk(numeric_ctl_pkg::OFS_IPTR, r64[51:32]);
			rchk(numeric_ctl_pkg::OFS_OPTR, optr_exp);
			rchk(numeric_ctl_pkg::OFS_OPCODE, r64[10:0]);
		end
		tag_exp = 16'hFFFF;
		repeat (4) begin
			v = next_rand();
			@(posedge i_mclk);
			{i_tag_we, i_tag_idx, i_tag_val} <= {1'h1, v[4:0]};
			@(posedge i_mclk);
			i_tag_we <= 1'h0;
			tag_exp[2 * v[4:2] +: 2] = v[1:0];
			rchk(numeric_ctl_pkg::OFS_TAG, tag_exp);
		end
		v = next_rand();
		wr(numeric_ctl_pkg::OFS_TAG, v);
		rchk(numeric_ctl_pkg::OFS_TAG, v);
		for (int k = 0; k < 16; k++) do_op(numeric_ctl_pkg::OPK_EXAMINE, {k[3:0], 3'h0}, 10'h0);
		for (int k = 0; k < 8; k++) begin
			do_op(numeric_ctl_pkg::OPK_EXAMINE, {k[2], 6'h0}, 10'h0);
			do_op(numeric_ctl_pkg::OPK_COMPARE, {5'h0, k[1:0]}, 10'h0);
		end
		for (int k = 0; k < 12; k++) begin
			v = next_rand();
			do_op(numeric_ctl_pkg::OPK_EXAMINE, {v[3:0], 3'h0}, 10'h0);
			do_op(numeric_ctl_pkg::OPK_REMAINDER, {1'h0, v[6:4], 1'((k / 3) % 2), 2'(k % 3)}, 10'h0);
		end
		flag_exp = 6'h0;
		do_op(numeric_ctl_pkg::OPK_OTHER, 7'h0, 10'h020);
		chk(o_exc_flags, flag_exp, "flags");
		for (int k = 0; k < 9; k++) begin
			do_op(numeric_ctl_pkg::OPK_OTHER, 7'h0, cause_of(k));
			flag_exp |= flag_of(k);
			chk(o_exc_flags, flag_exp, "flags");
			chk(o_resp, resp_of(k), "resp");
			chk(o_int, 1'h0, "int");
		end
		do_op(numeric_ctl_pkg::OPK_OTHER, 7'h0, 10'h0);
		chk(o_exc_flags, 6'h3F, "sticky");
		rchk(numeric_ctl_pkg::OFS_STATUS, 32'h3F);
		wr(numeric_ctl_pkg::OFS_CTRL, 32'h0337);
		rchk(numeric_ctl_pkg::OFS_STATUS, 32'hBF);
		chk({o_int, o_hold}, 2'h3, "int");
		wr(numeric_ctl_pkg::OFS_CTRL, 32'h03B7);
		rchk(numeric_ctl_pkg::OFS_STATUS, 32'hBF);
		chk({o_int, o_hold}, 2'h0, "int");
		do_op(numeric_ctl_pkg::OPK_EXAMINE, 7'h28, 10'h0);
		wr(numeric_ctl_pkg::OFS_STATUS, 32'h37);
		rchk(numeric_ctl_pkg::OFS_STATUS, 32'h88);
		wr(numeric_ctl_pkg::OFS_STATUS, 32'h08);
		rchk(numeric_ctl_pkg::OFS_STATUS, 32'h0);
		for (int k = 3; k < 9; k++) begin
			wr(numeric_ctl_pkg::OFS_CTRL, 32'h033F & ~{26'h0, flag_of(k)});
			do_op(numeric_ctl_pkg::OPK_OTHER, 7'h0, cause_of(k));
			chk({o_irq_bit, o_int, o_hold}, 3'h7, "irq");
			wr(numeric_ctl_pkg::OFS_STATUS, 32'h3F);
			rchk(numeric_ctl_pkg::OFS_STATUS, 32'h0);
		end
		stop_test();
	end
endmodule : numeric_control_exception_logic_tb_top
